// [debug_cmd_exec.sv]
// Command executor of the single-wire background debug logic.
// Assumes an outside framer that delivers command bytes, sends reply bytes and
// times acknowledge pulses; memory and CPU answer with one-cycle done strobes.
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
module debug_cmd_exec (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Debug wire pin
   input wire logic debug_wire_pin_i,
   output logic debug_wire_pin_o,
   output logic debug_wire_pin_oe,
   // Byte stream from and to the serial framer
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   output logic tx_valid,
   output logic [7:0] tx_byte,
   input wire logic tx_ready,
   output logic ack_pulse,
   output logic ack_long,
   // Memory access port
   output logic mem_req,
   output logic mem_we,
   output logic [23:0] mem_addr,
   output logic [1:0] mem_size,
   output logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_done,
   input wire logic mem_timeout,
   // CPU control port
   output logic cpu_halt_req,
   output logic cpu_resume,
   output logic cpu_reg_req,
   output logic [4:0] cpu_register_number,
   input wire logic [31:0] cpu_reg_data,
   input wire logic cpu_reg_done,
   input wire logic cpu_halted,
   input wire logic cpu_in_wait
);
   import debug_cmd_pkg::*;

   // =====
   // Helpers
   function automatic logic [2:0] size_bytes(input logic [1:0] sz);
      unique case (sz)
         SZ_BYTE: size_bytes = 3'd1;
         SZ_WORD: size_bytes = 3'd2;
         default: size_bytes = 3'd4;
      endcase
   endfunction

   // Longword accesses are forced onto a four-byte boundary.
   function automatic logic [23:0] align(input logic [23:0] a, input logic [1:0] sz);
      align = (sz == SZ_LONG) ? {a[23:2], 2'b00} : a;
   endfunction

   // Left-justifies the low n bytes of data, optionally after a status byte.
   function automatic logic [39:0] pack(input logic [31:0] data, input logic [2:0] n,
                                        input logic ws, input logic [7:0] st);
      logic [39:0] body;
      body = {data, 8'h00} << ({3'b000, 3'd4 - n} * 6'd8);
      pack = ws ? {st, body[39:8]} : body;
   endfunction

   // =====
   // State
   cmd_state_type state_q, state_d;
   sync_state_type sstate_q, sstate_d;
   logic [SYNC_CNT_W-1:0] scnt_q, scnt_d;
   logic [7:0] cmd_q, cmd_d;
   logic [23:0] ptr_q, ptr_d;
   logic [2:0] cnt_q, cnt_d;
   logic [39:0] txbuf_q, txbuf_d;
   logic [2:0] txcnt_q, txcnt_d;
   logic skip_q, skip_d;
   logic ack_en_q, ack_en_d;
   logic dbg_en_q, dbg_en_d;
   logic halt_pend_q, halt_pend_d;
   logic ill_q, ill_d;
   logic no_response_flag_q, no_response_flag_d;
   logic rd_chain_q, rd_chain_d;
   logic wr_chain_q, wr_chain_d;
   logic ack_pulse_q, ack_pulse_d;
   logic ack_long_q, ack_long_d;
   logic mem_req_q, mem_req_d;
   logic mem_we_q, mem_we_d;
   logic [23:0] mem_addr_q, mem_addr_d;
   logic [1:0] mem_size_q, mem_size_d;
   logic [31:0] mem_wdata_q, mem_wdata_d;
   logic cpu_resume_q, cpu_resume_d;
   logic cpu_reg_req_q, cpu_reg_req_d;
   logic [4:0] reg_num_q, reg_num_d;
   logic wb_ack_q, wb_ack_d;
   logic [31:0] wb_dat_q, wb_dat_d;
   logic sync_abort;
   logic [7:0] status_now;
   logic [1:0] sz_rx;
   logic [1:0] sz_cmd;
   logic ws_cmd;

   assign sz_rx = rx_byte[SZ_LSB +: 2];
   assign sz_cmd = cmd_q[SZ_LSB +: 2];
   assign ws_cmd = cmd_q[VAR_WS_BIT];

   // Status byte reflects flags as they stand after the current access.
   always_comb begin
      status_now = 8'h00;
      status_now[ST_ILLEGAL] = ill_d;
      status_now[ST_NO_RESPONSE_FLAG] = no_response_flag_d;
      status_now[ST_HALTED] = cpu_halted;
      status_now[ST_WAIT] = cpu_in_wait;
      status_now[ST_ENABLE] = dbg_en_q;
      status_now[ST_ACKEN] = ack_en_q;
   end

   // =====
   // Resync detection and response pulse
   always_comb begin
      sstate_d = sstate_q;
      scnt_d = scnt_q;
      sync_abort = 1'b0;
      unique case (sstate_q)
         SY_WATCH: begin
            scnt_d = '0;
            if (!debug_wire_pin_i) begin
               scnt_d = scnt_q + 1'b1;
               if (scnt_q == SYNC_CNT_W'(SYNC_DETECT_CYCLES - 1)) begin
                  sstate_d = SY_LONG;
               end
            end
         end
         SY_LONG: begin
            scnt_d = '0;
            if (debug_wire_pin_i) begin
               sync_abort = 1'b1;
               sstate_d = SY_DELAY;
            end
         end
         SY_DELAY: begin
            scnt_d = scnt_q + 1'b1;
            if (scnt_q == SYNC_CNT_W'(SYNC_DELAY_CYCLES - 1)) begin
               scnt_d = '0;
               sstate_d = SY_DRIVE;
            end
         end
         SY_DRIVE: begin
            scnt_d = scnt_q + 1'b1;
            if (scnt_q == SYNC_CNT_W'(SYNC_PULSE_CYCLES - 1)) begin
               scnt_d = '0;
               sstate_d = SY_SPEEDUP;
            end
         end
         SY_SPEEDUP: sstate_d = SY_WATCH;
      endcase
   end

   assign debug_wire_pin_oe = (sstate_q == SY_DRIVE) || (sstate_q == SY_SPEEDUP);
   assign debug_wire_pin_o = (sstate_q == SY_SPEEDUP);

   // =====
   // Command execution
   always_comb begin
      state_d = state_q;
      cmd_d = cmd_q;
      ptr_d = ptr_q;
      cnt_d = cnt_q;
      txbuf_d = txbuf_q;
      txcnt_d = txcnt_q;
      skip_d = skip_q;
      ack_en_d = ack_en_q;
      dbg_en_d = dbg_en_q;
      halt_pend_d = halt_pend_q && !cpu_halted;
      ill_d = ill_q;
      no_response_flag_d = no_response_flag_q;
      rd_chain_d = rd_chain_q;
      wr_chain_d = wr_chain_q;
      ack_pulse_d = 1'b0;
      ack_long_d = 1'b0;
      mem_req_d = 1'b0;
      mem_we_d = mem_we_q;
      mem_addr_d = mem_addr_q;
      mem_size_d = mem_size_q;
      mem_wdata_d = mem_wdata_q;
      cpu_resume_d = 1'b0;
      cpu_reg_req_d = 1'b0;
      reg_num_d = reg_num_q;
      wb_ack_d = wb_cyc_i && wb_stb_i && !wb_ack_q;
      wb_dat_d = 32'h0000_0000;

      // Software access: enable bit is read-write, flags clear on a written one.
      if (wb_ack_d) begin
         unique case (wb_adr_i)
            REG_CTRL: wb_dat_d[CTRL_ENABLE] = dbg_en_q;
            REG_STATUS: wb_dat_d[7:0] = status_now;
            REG_POINTER: wb_dat_d[23:0] = ptr_q;
            default: wb_dat_d = 32'h0000_0000;
         endcase
         if (wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == REG_CTRL) begin
               dbg_en_d = wb_dat_i[CTRL_ENABLE];
            end
            if (wb_adr_i == REG_STATUS) begin
               if (wb_dat_i[ST_ILLEGAL]) ill_d = 1'b0;
               if (wb_dat_i[ST_NO_RESPONSE_FLAG]) no_response_flag_d = 1'b0;
            end
         end
      end

      unique case (state_q)
         ST_IDLE: begin
            if (rx_valid) begin
               cmd_d = rx_byte;
               cnt_d = '0;
               skip_d = 1'b0;
               rd_chain_d = 1'b0;
               wr_chain_d = 1'b0;
               if (rx_byte == CMD_NOP) begin
                  rd_chain_d = rd_chain_q;
                  wr_chain_d = wr_chain_q;
               end else if (rx_byte == CMD_ACK_ON) begin
                  ack_en_d = 1'b1;
                  ack_pulse_d = 1'b1;
               end else if (rx_byte == CMD_ACK_OFF) begin
                  ack_en_d = 1'b0;
               end else if (rx_byte == CMD_HALT) begin
                  if (dbg_en_q) begin
                     halt_pend_d = 1'b1;
                     state_d = ST_HALT_WAIT;
                  end
               end else if (rx_byte == CMD_RESUME || rx_byte == CMD_RESUME_UNTIL) begin
                  if (!cpu_halted) begin
                     ill_d = 1'b1;
                  end else begin
                     cpu_resume_d = 1'b1;
                     state_d = ST_RUN_WAIT;
                  end
               end else if (rx_byte[7:5] == FAM_REG) begin
                  reg_num_d = rx_byte[4:0];
                  if (!cpu_halted) begin
                     ill_d = 1'b1;
                     txbuf_d = pack({4{ERR_BYTE}}, 3'd4, 1'b0, 8'h00);
                     txcnt_d = 3'd4;
                     state_d = ST_SEND;
                  end else begin
                     cpu_reg_req_d = 1'b1;
                     state_d = ST_REG;
                  end
               end else if (rx_byte[7:4] == FAM_READ) begin
                  if (!rx_byte[VAR_BLOCK_BIT]) begin
                     rd_chain_d = 1'b1;
                     state_d = ST_ADDR;
                  end else if (rd_chain_q) begin
                     rd_chain_d = 1'b1;
                     mem_we_d = 1'b0;
                     mem_size_d = sz_rx;
                     mem_addr_d = align(ptr_q, sz_rx);
                     mem_req_d = 1'b1;
                     state_d = ST_MEM;
                  end else begin
                     ill_d = 1'b1;
                     txbuf_d = pack({4{ERR_BYTE}}, size_bytes(sz_rx), rx_byte[VAR_WS_BIT], status_now);
                     txcnt_d = size_bytes(sz_rx) + {2'b00, rx_byte[VAR_WS_BIT]};
                     state_d = ST_SEND;
                  end
               end else if (rx_byte[7:4] == FAM_WRITE) begin
                  if (!rx_byte[VAR_BLOCK_BIT]) begin
                     wr_chain_d = 1'b1;
                     state_d = ST_ADDR;
                  end else begin
                     wr_chain_d = wr_chain_q;
                     skip_d = !wr_chain_q;
                     if (!wr_chain_q) ill_d = 1'b1;
                     mem_size_d = sz_rx;
                     mem_addr_d = align(ptr_q, sz_rx);
                     mem_wdata_d = '0;
                     state_d = ST_WDATA;
                  end
               end
            end
         end
         ST_ADDR: begin
            if (rx_valid) begin
               mem_addr_d = {mem_addr_q[15:0], rx_byte};
               cnt_d = cnt_q + 1'b1;
               if (cnt_q == 3'd2) begin
                  cnt_d = '0;
                  mem_size_d = sz_cmd;
                  mem_addr_d = align({mem_addr_q[15:0], rx_byte}, sz_cmd);
                  mem_wdata_d = '0;
                  if (cmd_q[7:4] == FAM_WRITE) begin
                     state_d = ST_WDATA;
                  end else begin
                     mem_we_d = 1'b0;
                     mem_req_d = 1'b1;
                     state_d = ST_MEM;
                  end
               end
            end
         end
         ST_WDATA: begin
            if (rx_valid) begin
               mem_wdata_d = {mem_wdata_q[23:0], rx_byte};
               cnt_d = cnt_q + 1'b1;
               if (cnt_q == size_bytes(mem_size_q) - 3'd1) begin
                  if (skip_q) begin
                     txbuf_d = pack(32'h0000_0000, 3'd0, 1'b1, status_now);
                     txcnt_d = {2'b00, ws_cmd};
                     state_d = ws_cmd ? ST_SEND : ST_IDLE;
                  end else begin
                     mem_we_d = 1'b1;
                     mem_req_d = 1'b1;
                     state_d = ST_MEM;
                  end
               end
            end
         end
         ST_MEM: begin
            if (mem_done) begin
               if (mem_timeout) begin
                  no_response_flag_d = 1'b1;
               end
               ptr_d = mem_addr_q + {21'h000000, size_bytes(mem_size_q)};
               if (mem_we_q) begin
                  ack_pulse_d = ack_en_q && !ws_cmd;
                  txbuf_d = pack(32'h0000_0000, 3'd0, 1'b1, status_now);
                  txcnt_d = {2'b00, ws_cmd};
                  state_d = ws_cmd ? ST_SEND : ST_IDLE;
               end else begin
                  ack_pulse_d = ack_en_q && !ws_cmd;
                  txbuf_d = pack(mem_timeout ? {4{ERR_BYTE}} : mem_rdata, size_bytes(mem_size_q),
                                 ws_cmd, status_now);
                  txcnt_d = size_bytes(mem_size_q) + {2'b00, ws_cmd};
                  state_d = ST_SEND;
               end
            end
         end
         ST_REG: begin
            if (cpu_reg_done) begin
               ack_pulse_d = ack_en_q;
               txbuf_d = pack(cpu_reg_data, 3'd4, 1'b0, 8'h00);
               txcnt_d = 3'd4;
               state_d = ST_SEND;
            end
         end
         ST_SEND: begin
            if (tx_ready) begin
               txbuf_d = {txbuf_q[31:0], 8'h00};
               txcnt_d = txcnt_q - 1'b1;
               if (txcnt_q == 3'd1) begin
                  state_d = ST_IDLE;
               end
            end
         end
         ST_HALT_WAIT: begin
            if (cpu_halted) begin
               ack_pulse_d = ack_en_q;
               state_d = ST_IDLE;
            end else if (cpu_in_wait) begin
               no_response_flag_d = 1'b1;
               ack_long_d = ack_en_q;
               state_d = ST_IDLE;
            end
         end
         ST_RUN_WAIT: begin
            if (!cpu_halted) begin
               if (cmd_q == CMD_RESUME_UNTIL && ack_en_q) begin
                  state_d = ST_UNTIL_WAIT;
               end else begin
                  ack_pulse_d = ack_en_q;
                  state_d = ST_IDLE;
               end
            end
         end
         ST_UNTIL_WAIT: begin
            if (cpu_halted) begin
               ack_pulse_d = 1'b1;
               state_d = ST_IDLE;
            end
         end
      endcase

      // A resync drops any partial command and reopens both block chains.
      if (sync_abort) begin
         state_d = ST_IDLE;
         rd_chain_d = 1'b1;
         wr_chain_d = 1'b1;
         mem_req_d = 1'b0;
         cpu_reg_req_d = 1'b0;
         ack_pulse_d = 1'b0;
         ack_long_d = 1'b0;
         txcnt_d = '0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= ST_IDLE;
         sstate_q <= SY_WATCH;
         mem_size_q <= SZ_BYTE;
         {rd_chain_q, wr_chain_q} <= 2'h3;
         {scnt_q, cmd_q, ptr_q, cnt_q, txbuf_q, txcnt_q, skip_q, ack_en_q, dbg_en_q, halt_pend_q, ill_q} <= '0;
         {no_response_flag_q, ack_pulse_q, ack_long_q, mem_req_q, mem_we_q, mem_addr_q, mem_wdata_q, cpu_resume_q} <= '0;
         {cpu_reg_req_q, reg_num_q, wb_ack_q, wb_dat_q} <= '0;
      end else begin
         state_q <= state_d;
         sstate_q <= sstate_d;
         mem_size_q <= mem_size_d;
         {rd_chain_q, wr_chain_q} <= {rd_chain_d, wr_chain_d};
         {scnt_q, cmd_q, ptr_q, cnt_q, txbuf_q, txcnt_q, skip_q, ack_en_q, dbg_en_q, halt_pend_q, ill_q} <=
            {scnt_d, cmd_d, ptr_d, cnt_d, txbuf_d, txcnt_d, skip_d, ack_en_d, dbg_en_d, halt_pend_d, ill_d};
         {no_response_flag_q, ack_pulse_q, ack_long_q, mem_req_q, mem_we_q, mem_addr_q, mem_wdata_q, cpu_resume_q} <=
            {no_response_flag_d, ack_pulse_d, ack_long_d, mem_req_d, mem_we_d, mem_addr_d, mem_wdata_d, cpu_resume_d};
         {cpu_reg_req_q, reg_num_q, wb_ack_q, wb_dat_q} <= {cpu_reg_req_d, reg_num_d, wb_ack_d, wb_dat_d};
      end
   end

   // =====
   // Outputs
   assign wb_ack_o = wb_ack_q;
   assign wb_dat_o = wb_dat_q;
   assign tx_valid = (state_q == ST_SEND);
   assign tx_byte = txbuf_q[39:32];
   assign ack_pulse = ack_pulse_q;
   assign ack_long = ack_long_q;
   assign mem_req = mem_req_q;
   assign mem_we = mem_we_q;
   assign mem_addr = mem_addr_q;
   assign mem_size = mem_size_q;
   assign mem_wdata = mem_wdata_q;
   assign cpu_halt_req = halt_pend_q;
   assign cpu_resume = cpu_resume_q;
   assign cpu_reg_req = cpu_reg_req_q;
   assign cpu_register_number = reg_num_q;

endmodule

// [debug_cmd_pkg.sv]
// Constants, command codes and types for the single-wire debug command executor.
// Assumes a byte-level serial framer outside this block and a 40 MHz core_clk.
// Operation
// - Handshake-off command disables later acknowledges and is itself never acknowledged.
// - Handshake-on runs inside debug logic, acknowledges, enables later acknowledges.
// - Code 0x04 halts after current instruction if debug enable set, else ignored.
// - Halt in wait mode stays pending, sets no-response, long acknowledge once.
// - Pending halt shows no-response and wait set, halted clear; memory commands allowed.
// - Block read uses a pointer advanced by operand size after every read.
// - Block read with status sends status byte after read, before data.
// - Block read legal only after resync, no-op, single read or block read.
// - Operand size is decoded afresh on every block read and block write.
// - Block write stores at pointer then advances it by operand size.
// - Block write with status sends status after data; acknowledge after write ends. Here ack_pulse stays low for the status variants.
// - Block write legal only after resync, no-op, single write or block write.
// - Resume leaves halted state, acknowledges on exit; illegal when not halted.
// - Resume-until acknowledges only on return to halted state, with no timeout.
// - Without handshake resume-until equals resume; illegal when not halted.
// - Register read returns 32 bits, acknowledge first; illegal when not halted.
// - Longword accesses force the two low address bits to zero.
// - Single read with status sends status byte before the read data.
// - Long low on wire aborts command; device answers with 128-cycle low pulse.
package debug_cmd_pkg;

   // =====
   // Timing
   localparam int SYNC_DETECT_CYCLES = 128;
   localparam int SYNC_DELAY_CYCLES = 16;
   localparam int SYNC_PULSE_CYCLES = 128;
   localparam int SYNC_CNT_W = 8;

   // =====
   // Command codes
   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_HALT = 8'h04;
   localparam logic [7:0] CMD_RESUME = 8'h08;
   localparam logic [7:0] CMD_RESUME_UNTIL = 8'h0c;
   localparam logic [7:0] CMD_ACK_ON = 8'hd5;
   localparam logic [7:0] CMD_ACK_OFF = 8'hd6;
   localparam logic [3:0] FAM_WRITE = 4'h1;
   localparam logic [3:0] FAM_READ = 4'h3;
   localparam logic [2:0] FAM_REG = 3'h3;
   localparam int VAR_WS_BIT = 0;
   localparam int VAR_BLOCK_BIT = 1;
   localparam int SZ_LSB = 2;
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_WORD = 2'h1;
   localparam logic [1:0] SZ_LONG = 2'h2;
   localparam logic [7:0] ERR_BYTE = 8'hee;

   // =====
   // Status low byte layout
   localparam int ST_ILLEGAL = 0;
   localparam int ST_NO_RESPONSE_FLAG = 1;
   localparam int ST_HALTED = 2;
   localparam int ST_WAIT = 3;
   localparam int ST_ENABLE = 4;
   localparam int ST_ACKEN = 5;

   // =====
   // Wishbone register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_POINTER = 8'h08;
   localparam int CTRL_ENABLE = 0;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_WDATA, ST_MEM, ST_REG, ST_SEND,
      ST_HALT_WAIT, ST_RUN_WAIT, ST_UNTIL_WAIT
   } cmd_state_type;

   typedef enum logic [2:0] {
      SY_WATCH, SY_LONG, SY_DELAY, SY_DRIVE, SY_SPEEDUP
   } sync_state_type;

endpackage

// [debug_cmd_exec_asserts.sv]
// Port-level checks for the debug command executor.
// Assumes debug_cmd_pkg is compiled first; bound to every executor instance.
`timescale 1ns/10ps
module debug_cmd_exec_asserts (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Watched ports
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic debug_wire_pin_o,
   input wire logic debug_wire_pin_oe,
   input wire logic tx_valid,
   input wire logic [7:0] tx_byte,
   input wire logic tx_ready,
   input wire logic mem_req,
   input wire logic [23:0] mem_addr,
   input wire logic [1:0] mem_size,
   input wire logic cpu_halt_req,
   input wire logic cpu_halted,
   input wire logic cpu_reg_req
);
   import debug_cmd_pkg::*;
   logic [7:0] drv_q;
   logic [7:0] drv_d;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Counts how long the pin has been driven in one stretch.
   always_comb drv_d = debug_wire_pin_oe ? drv_q + 8'h01 : 8'h00;
   always_ff @(posedge core_clk) drv_q <= rst ? 8'h00 : drv_d;
   sequence s_wb_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_sync_low; (debug_wire_pin_oe && !debug_wire_pin_o) [*8]; endsequence
   property p_wb_answer; s_wb_req |=> wb_ack_o ##1 !wb_ack_o; endproperty
   a_wb_answer: assert property (p_wb_answer) else $error("bad ack timing");
   property p_long_align; mem_req && mem_size == SZ_LONG |-> mem_addr[1:0] == 2'h0; endproperty
   a_long_align: assert property (p_long_align) else $error("unaligned long");
   property p_halt_hold; cpu_halt_req && !cpu_halted |=> cpu_halt_req; endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("halt dropped");
   property p_reg_halted; cpu_reg_req |-> cpu_halted; endproperty
   a_reg_halted: assert property (p_reg_halted) else $error("reg while running");
   property p_sync_low; $rose(debug_wire_pin_oe) |-> s_sync_low; endproperty
   a_sync_low: assert property (p_sync_low) else $error("sync answer not low");
   property p_sync_len; $fell(debug_wire_pin_oe) |-> drv_q == 8'h81 && $past(debug_wire_pin_o); endproperty
   a_sync_len: assert property (p_sync_len) else $error("sync length");
   property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte); endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("reply byte not held");
   property p_mem_pulse; mem_req |=> !mem_req; endproperty
   a_mem_pulse: assert property (p_mem_pulse) else $error("mem req long");
endmodule
bind debug_cmd_exec debug_cmd_exec_asserts debug_cmd_exec_asserts_inst (.core_clk, .rst, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .debug_wire_pin_o, .debug_wire_pin_oe, .tx_valid, .tx_byte, .tx_ready, .mem_req, .mem_addr,
   .mem_size, .cpu_halt_req, .cpu_halted, .cpu_reg_req);

// [target_side_model.sv]
// Behavioural memory and CPU that answer the executor's requests.
// Assumes the bench supplies clock and reset.
`timescale 1ns/10ps
module target_side_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Requests
   input wire logic mem_req,
   input wire logic [23:0] mem_addr,
   input wire logic cpu_halt_req,
   input wire logic cpu_resume,
   input wire logic cpu_reg_req,
   input wire logic [4:0] cpu_register_number,
   // Answers
   output logic [31:0] mem_rdata,
   output logic mem_done,
   output logic [31:0] cpu_reg_data,
   output logic cpu_reg_done,
   output logic cpu_halted
);
   logic [1:0] dly_q;
   // Data lines toggle outside the answer cycle so stale values are never read.
   always @(posedge core_clk) begin
      dly_q <= rst ? 2'h0 : {dly_q[0], mem_req};
      mem_done <= dly_q[1] && !rst;
      mem_rdata <= dly_q[1] ? {8'h00, mem_addr} : ~mem_rdata;
      cpu_reg_done <= cpu_reg_req;
      cpu_reg_data <= cpu_reg_req ? {27'h0, cpu_register_number} : ~cpu_reg_data;
      if (rst || cpu_resume)
         cpu_halted <= 1'b0;
      else if (cpu_halt_req)
         cpu_halted <= 1'b1;
   end
endmodule

// [test_debug_cmd_exec.sv]
// Self-checking bench for the debug command executor.
// Assumes package, checker and target model are compiled first.
`timescale 1ns/10ps
module test_debug_cmd_exec;
   import debug_cmd_pkg::*;
   logic core_clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, rx_valid = 0, tx_ready = 0, pin_low = 0;
   logic [7:0] wb_adr_i = 0, rx_byte = 0;
   logic [31:0] wb_dat_i = 0, exp_q[$];
   logic [15:0] r = 16'h0003;
   logic [23:0] p;
   int n_fail = 0, compares = 0, cycles = 0;
   wire logic [31:0] wb_dat_o, mem_rdata, cpu_reg_data;
   wire logic [23:0] mem_addr;
   wire logic [7:0] tx_byte;
   wire logic [4:0] cpu_register_number;
   wire logic [1:0] mem_size;
   wire logic wb_ack_o, pin_o, pin_oe, tx_valid, mem_req, mem_done;
   wire logic cpu_halt_req, cpu_resume, cpu_reg_req, cpu_reg_done, cpu_halted;
   always #12.5 core_clk = ~core_clk;
   debug_cmd_exec debug_cmd_exec_inst (.core_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf),
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .debug_wire_pin_i(pin_oe ? pin_o : !pin_low), .debug_wire_pin_o(pin_o),
      .debug_wire_pin_oe(pin_oe), .rx_valid, .rx_byte, .tx_valid, .tx_byte, .tx_ready, .ack_pulse(), .ack_long(),
      .mem_req, .mem_we(), .mem_addr, .mem_size, .mem_wdata(), .mem_rdata, .mem_done, .mem_timeout(1'b0),
      .cpu_halt_req, .cpu_resume, .cpu_reg_req, .cpu_register_number, .cpu_reg_data, .cpu_reg_done, .cpu_halted,
      .cpu_in_wait(1'b0));
   target_side_model target_side_model_inst (.core_clk, .rst, .mem_req, .mem_addr, .cpu_halt_req, .cpu_resume,
      .cpu_reg_req, .cpu_register_number, .mem_rdata, .mem_done, .cpu_reg_data, .cpu_reg_done, .cpu_halted);
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      compares++;
      if (seen !== want) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, seen, want);
      end
   endtask
   task automatic test_done;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
      do @(posedge core_clk); while (wb_ack_o !== 1'b1);
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] adr, input logic [31:0] want);
      exp_q.push_back(want);
      wb(1'b0, adr, 32'h0);
   endtask
   task automatic exp_b(input logic [7:0] v);
      exp_q.push_back({24'h0, v});
   endtask
   task automatic exp4(input logic [31:0] d);
      for (int i = 3; i >= 0; i--) exp_b(d[8*i +: 8]);
   endtask
   // Sends whole commands, then lets replies drain and keeps the host spacing.
   task automatic cmd(input logic [7:0] b[$]);
      foreach (b[i]) begin
         {rx_valid, rx_byte} <= {1'b1, b[i]};
         @(posedge core_clk);
      end
      rx_valid <= 1'b0;
      do @(posedge core_clk); while (exp_q.size() != 0);
      repeat (16) @(posedge core_clk);
   endtask
   always @(posedge core_clk) begin
      r <= lfsr(r);
      tx_ready <= r[0] | r[1];
      cycles <= cycles + 1;
      if ((tx_valid && tx_ready) || (wb_ack_o && !wb_we_i))
         check(tx_valid ? {24'h0, tx_byte} : wb_dat_o, exp_q.size() ? exp_q.pop_front() : 32'hx);
      if (cycles == 5000) begin
         n_fail++;
         test_done;
      end
   end
   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      wb(1'b1, REG_CTRL, 32'h1);
      rd(REG_CTRL, 32'h1);
      rd(8'h0c, 32'h0);
      $display("registers done");
      p = {8'h01, r[15:2], 2'b00};
      exp_b(8'h10);
      exp4({8'h00, p});
      cmd('{8'h39, p[23:16], p[15:8], p[7:0] | 8'h03});
      p = p + 24'h4;
      exp_b(p[15:8]);
      exp_b(p[7:0]);
      cmd('{8'h36});
      exp_b(p[7:0] + 8'h2);
      cmd('{8'h32});
      cmd('{8'h00});
      exp_b(8'h10);
      exp_b(p[7:0] + 8'h3);
      cmd('{8'h33});
      rd(REG_POINTER, {8'h00, p + 24'h4});
      $display("memory done");
      cmd('{CMD_ACK_ON});
      rd(REG_STATUS, 32'h30);
      exp_b(ERR_BYTE);
      cmd('{8'h32});
      rd(REG_STATUS, 32'h31);
      wb(1'b1, REG_STATUS, 32'h1);
      cmd('{CMD_ACK_OFF});
      rd(REG_STATUS, 32'h10);
      $display("handshake done");
      exp4(32'heeeeeeee);
      cmd('{8'h63});
      rd(REG_STATUS, 32'h11);
      wb(1'b1, REG_STATUS, 32'h1);
      cmd('{CMD_HALT});
      rd(REG_STATUS, 32'h14);
      exp4({27'h0, p[4:0]});
      cmd('{8'h60 + {3'h0, p[4:0]}});
      cmd('{CMD_RESUME});
      rd(REG_STATUS, 32'h10);
      cmd('{CMD_RESUME_UNTIL});
      rd(REG_STATUS, 32'h11);
      $display("cpu done");
      pin_low <= 1'b1;
      repeat (140) @(posedge core_clk);
      pin_low <= 1'b0;
      do @(posedge core_clk); while (!pin_oe);
      do @(posedge core_clk); while (pin_oe);
      $display("resync done");
      test_done;
   end
endmodule
